/* hdl/pin_sync.sv */
// Purpose: Two flop synchroniser for a group of pin levels
// Assumes: Each bit is an independent level
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk, // System clock
	input  wire logic             rstn,    // Async reset, active low
	input  wire logic [WIDTH-1:0] din,     // Asynchronous pin levels
	output logic      [WIDTH-1:0] dout     // Synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s s_reg;
	sync_s s_next;

	if (WIDTH < 1) begin : g_bad
		$error("pin_sync needs WIDTH of at least 1");
	end

	always_comb begin
		s_next.meta   = din;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign dout = s_reg.stable;
endmodule

/* hdl/timer_a_event_counter.sv */
// Purpose: Bank of event counter timers with register port and interrupt
// Assumes: Pins are asynchronous; tb2_ovf is a sys_clk pulse
// Notes:   Neighbour overflows feed a timer one cycle after they occur
//
// Overview of operation
// RL1: Source is pin, B2, lower or higher neighbour
// RL2: Source select value 00b picks the pin
// RL3: Edge polarity bit applies only to pin source
// RL4: Direction bit picks increment or decrement
// RL5: Reload type reloads on wrap; free-run does not
// RL6: Reload period FFFFh-n+1 up, n+1 down
// RL7: Timer value is a full 16-bit register
// RL8: Setting the run bit starts counting
// RL9: Clearing the run bit halts counting
// RL10: Every over/underflow raises the interrupt request
// RL11: Reading the timer returns the live count
// RL12: Stopped write loads reload and counter
// RL13: Running write loads reload register only
// RL14: Pulse output toggles on wrap, low when stopped
// RL15: Inverted polarity makes idle output high
// RL16: Polarity bit acts only with pulse output enabled
// RL17: Pins serve as port or timer function
// RL18: Writing one resets the shared prescaler
// RL19: Wrap FFFFh-0000h up, 0000h-FFFFh down, one cycle
`timescale 1ns/1ns
module timer_a_event_counter #(
	parameter int NT      = timer_a_pkg::NUM_TIMERS,
	parameter int PRESC_W = timer_a_pkg::PRESC_W
) (
	input  wire logic                           sys_clk,                // System clock, 250 MHz
	input  wire logic                           rstn,                   // Async reset, active low
	input  wire logic [timer_a_pkg::ADDR_W-1:0] addr,                   // Register byte address
	input  wire logic [timer_a_pkg::DATA_W-1:0] wdata,                  // Write data
	input  wire logic                           wr_stb,                 // Write strobe
	input  wire logic                           rd_stb,                 // Read strobe
	output logic      [timer_a_pkg::DATA_W-1:0] rdata,                  // Read data, one cycle later
	input  wire logic [NT-1:0]                  timer_event_input_pin,  // External count pins
	input  wire logic                           tb2_ovf,                // Timer B2 wrap pulse
	output logic      [NT-1:0]                  timer_pulse_output_pin, // Pulse or port output pins
	output logic                                irq                     // Interrupt, level
);
	import timer_a_pkg::*;

	typedef struct packed {
		logic [NT-1:0]             run;
		logic [NT-1:0]             dir;
		logic [NT-1:0][SRC_W-1:0]  src;
		logic [NT-1:0]             pol;
		logic [NT-1:0]             infn;
		logic [NT-1:0]             gpo;
		logic [NT-1:0][MODE_W-1:0] mode;
		logic [NT-1:0]             prev;
		logic [NT-1:0]             tog;
		logic [NT-1:0]             pins;
		logic [NT-1:0]             stat;
		logic [NT-1:0]             mask;
		logic                      irq;
		logic [PRESC_W-1:0]        presc;
		logic [DATA_W-1:0]         rdata;
	} bank_s;

	bank_s s_reg;
	bank_s s_next;

	logic [NT-1:0]              pin_s;
	logic [NT-1:0]              tick;
	logic [NT-1:0]              twr;
	logic [NT-1:0]              covf;
	logic [NT-1:0][TIMER_W-1:0] cval;

	localparam logic [PRESC_W-1:0] PRESC_ONE = {{(PRESC_W-1){1'b0}}, 1'b1};

	if (NT < 2 || NT > 8) begin : g_bad_nt
		$error("timer bank supports 2 to 8 timers");
	end
	if (PRESC_W < 1 || PRESC_W > DATA_W) begin : g_bad_presc
		$error("prescaler width out of range");
	end

	function automatic logic [ADDR_W-1:0] slot(input logic [ADDR_W-1:0] base, input int idx);
		return base + ADDR_W'(OFS_STRIDE * idx);
	endfunction

	function automatic int lower_of(input int idx);
		return (idx == 0) ? NT - 1 : idx - 1;
	endfunction

	function automatic int higher_of(input int idx);
		return (idx == NT - 1) ? 0 : idx + 1;
	endfunction

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	pin_sync #(
		.WIDTH(NT)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rstn   (rstn),
		.din    (timer_event_input_pin),
		.dout   (pin_s)
	);

	// --------------------------------------------------------------
	// Count sources
	// --------------------------------------------------------------
	// Neighbour wraps come from registered pulses, so a ring of
	// chained timers never forms a combinational loop.
	always_comb begin
		logic edge_hit;
		edge_hit = 1'b0;
		for (int i = 0; i < NT; i++) begin
			// Pin path only when the input pin is given to the timer
			edge_hit = s_reg.infn[i] && (pin_s[i] != s_reg.prev[i]) && // RL17
				(pin_s[i] == s_reg.mode[i][MODE_EDGE_BIT]); // RL3
			unique case (src_sel_e'(s_reg.src[i])) // RL1 RL2
				SRC_PIN:    tick[i] = edge_hit;
				SRC_TB2:    tick[i] = tb2_ovf;
				SRC_LOWER:  tick[i] = covf[lower_of(i)];
				SRC_HIGHER: tick[i] = covf[higher_of(i)];
			endcase
		end
	end

	always_comb begin
		for (int i = 0; i < NT; i++) begin
			twr[i] = wr_stb && (addr == slot(OFS_TIMER_BASE, i));
		end
	end

	// --------------------------------------------------------------
	// Counters
	// --------------------------------------------------------------
	for (genvar g = 0; g < NT; g++) begin : g_ch
		timer_channel #(
			.WIDTH(TIMER_W)
		) u_ch (
			.sys_clk  (sys_clk),
			.rstn     (rstn),
			.run      (s_reg.run[g]),
			.count_up (s_reg.dir[g]),
			.free_run (s_reg.mode[g][MODE_FREE_BIT]),
			.tick     (tick[g]),
			.load     (twr[g]),
			.load_data(wdata[TIMER_W-1:0]), // RL7
			.value    (cval[g]),
			.ovf      (covf[g])
		);
	end

	// --------------------------------------------------------------
	// Register file, outputs and interrupt
	// --------------------------------------------------------------
	always_comb begin
		logic [NT-1:0] clr;
		clr          = '0;
		s_next       = s_reg;
		s_next.prev  = pin_s;
		s_next.rdata = '0;
		s_next.presc = s_reg.presc + PRESC_ONE;

		if (wr_stb) begin
			unique case (addr)
				OFS_START:    s_next.run  = wdata[NT-1:0]; // RL8 RL9
				OFS_DIR:      s_next.dir  = wdata[NT-1:0]; // RL4
				OFS_SRC:      s_next.src  = wdata[SRC_W*NT-1:0];
				OFS_POL:      s_next.pol  = wdata[NT-1:0];
				OFS_PINFN:    s_next.infn = wdata[NT-1:0];
				OFS_GPIO_OUT: s_next.gpo  = wdata[NT-1:0];
				OFS_IRQ_STAT: clr         = wdata[NT-1:0];
				OFS_IRQ_MASK: s_next.mask = wdata[NT-1:0];
				OFS_PRESC: begin
					if (wdata[PRESC_RESET_BIT]) begin
						s_next.presc = '0; // RL18
					end
				end
				default: begin
					for (int i = 0; i < NT; i++) begin
						if (addr == slot(OFS_MODE_BASE, i)) begin
							s_next.mode[i] = wdata[MODE_W-1:0];
						end
					end
				end
			endcase
		end

		if (rd_stb) begin
			unique case (addr)
				OFS_START:    s_next.rdata = DATA_W'(s_reg.run);
				OFS_DIR:      s_next.rdata = DATA_W'(s_reg.dir);
				OFS_SRC:      s_next.rdata = DATA_W'(s_reg.src);
				OFS_POL:      s_next.rdata = DATA_W'(s_reg.pol);
				OFS_PINFN:    s_next.rdata = DATA_W'(s_reg.infn);
				OFS_GPIO_OUT: s_next.rdata = DATA_W'(s_reg.gpo);
				OFS_PIN_IN:   s_next.rdata = DATA_W'(pin_s);
				OFS_PRESC:    s_next.rdata = DATA_W'(s_reg.presc);
				OFS_IRQ_STAT: s_next.rdata = DATA_W'(s_reg.stat);
				OFS_IRQ_MASK: s_next.rdata = DATA_W'(s_reg.mask);
				default: begin
					for (int i = 0; i < NT; i++) begin
						if (addr == slot(OFS_MODE_BASE, i)) begin
							s_next.rdata = DATA_W'(s_reg.mode[i]);
						end
						if (addr == slot(OFS_TIMER_BASE, i)) begin
							s_next.rdata = DATA_W'(cval[i]); // RL11
						end
					end
				end
			endcase
		end

		// A wrap in the clearing cycle keeps its bit set
		s_next.stat = (s_reg.stat & ~clr) | covf; // RL10
		s_next.irq  = |(s_next.stat & s_next.mask);

		for (int i = 0; i < NT; i++) begin
			if (!s_next.run[i]) begin
				s_next.tog[i] = 1'b0; // RL14
			end else if (covf[i] && s_reg.run[i]) begin
				s_next.tog[i] = ~s_reg.tog[i]; // RL14
			end
			// Polarity only matters on a pin given to the pulse output
			if (s_reg.mode[i][MODE_PULSE_BIT]) begin // RL16 RL17
				s_next.pins[i] = s_reg.tog[i] ^ s_reg.pol[i]; // RL15
			end else begin
				s_next.pins[i] = s_reg.gpo[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata                  = s_reg.rdata;
	assign timer_pulse_output_pin = s_reg.pins;
	assign irq                    = s_reg.irq;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	run_write_a: assert property (wr_stb && addr == OFS_START |=> s_reg.run == $past(wdata[NT-1:0])) else $error("run bits not written"); // RL8
	presc_clear_a: assert property (wr_stb && addr == OFS_PRESC && wdata[PRESC_RESET_BIT] |=> s_reg.presc == '0 ##1 s_reg.presc == PRESC_ONE) else $error("prescaler not reset"); // RL18

	for (genvar g = 0; g < NT; g++) begin : g_chk
		pin_source_a: assert property (tick[g] && s_reg.src[g] == SRC_PIN |-> s_reg.infn[g] && pin_s[g] != s_reg.prev[g] && pin_s[g] == s_reg.mode[g][MODE_EDGE_BIT]) else $error("pin tick on wrong edge"); // RL3
		chain_source_a: assert property (s_reg.src[g] == SRC_LOWER |-> tick[g] == covf[lower_of(g)]) else $error("lower neighbour not followed"); // RL1
		wrap_flag_a: assert property (covf[g] && s_reg.mask[g] |=> s_reg.stat[g] && irq) else $error("wrap did not raise interrupt"); // RL10
		idle_pin_a: assert property (!s_reg.run[g] && s_reg.mode[g][MODE_PULSE_BIT] |=> timer_pulse_output_pin[g] == $past(s_reg.pol[g])) else $error("idle output level wrong"); // RL15
		read_count_a: assert property (rd_stb && addr == slot(OFS_TIMER_BASE, g) |=> rdata == DATA_W'($past(cval[g]))) else $error("timer read wrong"); // RL11
	end

	wrap_c: cover property (covf[0] ##1 s_reg.stat[0]);
	irq_rise_c: cover property (!irq ##1 irq);
	toggle_c: cover property (s_reg.run[0] && s_reg.mode[0][MODE_PULSE_BIT] && $changed(timer_pulse_output_pin[0]));
	chain_c: cover property (s_reg.src[1] == SRC_LOWER && tick[1]);
endmodule

/* hdl/timer_a_pkg.sv */
// Purpose: Shared constants and types of the event counter timer bank
// Assumes: Byte addressed register port, one 32-bit word per register
// Notes:   Offsets are byte addresses; indexed registers step by one word
package timer_a_pkg;

	// --------------------------------------------------------------
	// Widths and sizes
	// --------------------------------------------------------------
	localparam int NUM_TIMERS = 5;
	localparam int TIMER_W    = 16;
	localparam int PRESC_W    = 8;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int MODE_W     = 4;
	localparam int SRC_W      = 2;

	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_START     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR       = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SRC       = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_POL       = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PINFN     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_GPIO_OUT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PIN_IN    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PRESC     = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_MODE_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_TIMER_BASE = 8'h60;
	localparam int                OFS_STRIDE    = 4;

	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int MODE_PULSE_BIT  = 0;
	localparam int MODE_FREE_BIT   = 1;
	localparam int MODE_EDGE_BIT   = 3;
	localparam int PRESC_RESET_BIT = 0;
	localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;

	typedef enum logic [SRC_W-1:0] {
		SRC_PIN    = 2'h0,
		SRC_TB2    = 2'h1,
		SRC_LOWER  = 2'h2,
		SRC_HIGHER = 2'h3
	} src_sel_e;

endpackage

/* hdl/timer_channel.sv */
// Purpose: One 16-bit up/down event counter with reload register
// Assumes: tick is a one cycle pulse on sys_clk
// Notes:   A write while running reaches the reload register, and the counter only through a reload wrap in the same cycle
`timescale 1ns/1ns
module timer_channel #(
	parameter int WIDTH = timer_a_pkg::TIMER_W
) (
	input  wire logic             sys_clk,   // System clock
	input  wire logic             rstn,      // Async reset, active low
	input  wire logic             run,       // Counting enabled
	input  wire logic             count_up,  // 1 increment, 0 decrement
	input  wire logic             free_run,  // 1 no reload on wrap
	input  wire logic             tick,      // Count source pulse
	input  wire logic             load,      // Timer register write
	input  wire logic [WIDTH-1:0] load_data, // Written value
	output logic      [WIDTH-1:0] value,     // Current count
	output logic                  ovf        // Over/underflow pulse
);
	import timer_a_pkg::*;

	localparam logic [WIDTH-1:0] MAXV = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic [WIDTH-1:0] rld;
		logic             ovf;
	} chan_s;

	chan_s s_reg;
	chan_s s_next;

	if (WIDTH < 2) begin : g_bad
		$error("timer_channel needs WIDTH of at least 2");
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb begin
		logic [WIDTH-1:0] rnext;
		rnext      = load ? load_data : s_reg.rld;
		s_next     = s_reg;
		s_next.ovf = 1'b0;
		if (load) begin
			s_next.rld = load_data; // RL13
		end
		if (run && tick) begin // RL8 RL9
			if (count_up) begin // RL4
				if (s_reg.cnt == MAXV) begin
					s_next.ovf = 1'b1; // RL19
					s_next.cnt = free_run ? '0 : rnext; // RL5 RL6
				end else begin
					s_next.cnt = s_reg.cnt + ONE;
				end
			end else begin
				if (s_reg.cnt == '0) begin
					s_next.ovf = 1'b1; // RL19
					s_next.cnt = free_run ? MAXV : rnext; // RL5 RL6
				end else begin
					s_next.cnt = s_reg.cnt - ONE;
				end
			end
		end
		if (load && !run) begin
			s_next.cnt = load_data; // RL12
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign value = s_reg.cnt;
	assign ovf   = s_reg.ovf;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// After a wrap edge without free-run the reload register already holds whatever the counter took
	up_wrap_a: assert property (run && tick && count_up && s_reg.cnt == MAXV |=> ovf && value == ($past(free_run) ? '0 : s_reg.rld)) else $error("overflow wrap wrong"); // RL19
	down_wrap_a: assert property (run && tick && !count_up && s_reg.cnt == '0 && free_run |=> ovf && value == MAXV) else $error("free-run underflow wrong"); // RL5
	step_dir_a: assert property (run && tick && !load && count_up && s_reg.cnt != MAXV |=> value == $past(s_reg.cnt) + ONE && !ovf) else $error("increment wrong"); // RL4
	load_stop_a: assert property (load && !run |=> value == $past(load_data) && s_reg.rld == $past(load_data)) else $error("stopped write wrong"); // RL12
	load_run_a: assert property (load && run && !tick |=> value == $past(s_reg.cnt) && s_reg.rld == $past(load_data)) else $error("running write reached counter"); // RL13
	halt_hold_a: assert property (!run && !load |=> $stable(value) && !ovf) else $error("counter moved while halted"); // RL9
	underflow_c: cover property (run && tick && !count_up && s_reg.cnt == '0);
endmodule

/* test/pulse_source.sv */
// Purpose: Far side model: external count pins and timer B2 wrap pulses
// Assumes: Requests are one cycle pulses on sys_clk, changed after the edge
// Notes:   A pin request gives one full high pulse, so each edge kind occurs once
`timescale 1ns/1ns
module pulse_source #(
	parameter int NT      = 5,
	parameter int PULSE_W = 10
) (
	input  wire logic          sys_clk, // System clock
	input  wire logic          rstn,    // Async reset, active low
	input  wire logic [NT-1:0] pin_req, // Start a pin pulse
	input  wire logic          tb2_req, // Request one B2 wrap
	output logic      [NT-1:0] pins,    // External count pins
	output logic               tb2_ovf  // B2 wrap pulse
);
	int left [NT];

	// ------------------------------------------------------------
	// Pulse generation
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pins <= '0;
			tb2_ovf <= 1'b0;
			for (int i = 0; i < NT; i++) left[i] <= 0;
		end else begin
			tb2_ovf <= tb2_req;
			for (int i = 0; i < NT; i++) begin
				if (pin_req[i]) left[i] <= PULSE_W;
				else if (left[i] > 0) left[i] <= left[i] - 1;
				// Wide pulse so the synchroniser cannot merge both edges
				pins[i] <= pin_req[i] || left[i] > 1;
			end
		end
	end
endmodule

/* test/testbench.sv */
// Purpose: Self-checking bench of the event counter bank against a queue-free model
// Assumes: Waits after each stimulus exceed the pin and wrap pipeline depth
// Notes:   Model counts each source event once, whatever its edge timing
`timescale 1ns/1ns
module testbench;
	import timer_a_pkg::*;
	logic        sys_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic [31:0] rdata;
	logic [4:0]  pins;
	logic        tb2_ovf;
	logic [4:0]  timer_pulse_output_pin;
	logic        irq;
	logic [4:0]  pin_req;
	logic        tb2_req;
	logic [4:0]  run_s, dir_s, pol_s, fn_s, gpio_s;
	logic [9:0]  src_s;
	logic [3:0]  mode_s [5];
	int          cnt [5], rld [5], stat, mask, seed, miscompares, n_compared;
	bit          tog [5];

	timer_a_event_counter u_timer_a_event_counter (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_event_input_pin(pins), .tb2_ovf(tb2_ovf),
		.timer_pulse_output_pin(timer_pulse_output_pin), .irq(irq));
	pulse_source u_pulse_source (.sys_clk(sys_clk), .rstn(rstn), .pin_req(pin_req), .tb2_req(tb2_req),
		.pins(pins), .tb2_ovf(tb2_ovf));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Bus tasks and model
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		case (a)
			OFS_START: run_s = d[4:0];
			OFS_DIR: dir_s = d[4:0];
			OFS_SRC: src_s = d[9:0];
			OFS_POL: pol_s = d[4:0];
			OFS_PINFN: fn_s = d[4:0];
			OFS_GPIO_OUT: gpio_s = d[4:0];
			OFS_IRQ_STAT: stat &= ~int'(d[4:0]);
			OFS_IRQ_MASK: mask = d[4:0];
			default: for (int i = 0; i < NUM_TIMERS; i++) begin
				if (a == 8'(OFS_MODE_BASE + OFS_STRIDE * i)) mode_s[i] = d[3:0];
				if (a == 8'(OFS_TIMER_BASE + OFS_STRIDE * i)) begin
					rld[i] = d[15:0];
					if (!run_s[i]) cnt[i] = d[15:0];
				end
			end
		endcase
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask

	// One counted event on timer i, with wrap chaining to neighbours
	task automatic tk(input int i);
		if (!run_s[i]) return;
		if (dir_s[i] && cnt[i] == 'hffff || !dir_s[i] && cnt[i] == 0) begin
			cnt[i] = mode_s[i][MODE_FREE_BIT] ? (dir_s[i] ? 0 : 'hffff) : rld[i];
			stat |= 1 << i;
			tog[i] ^= 1'b1;
			for (int j = 0; j < NUM_TIMERS; j++)
				if (src_s[2*j+:2] == SRC_LOWER && (j + 4) % 5 == i || src_s[2*j+:2] == SRC_HIGHER && (j + 1) % 5 == i)
					tk(j);
		end else cnt[i] = dir_s[i] ? cnt[i] + 1 : cnt[i] - 1;
	endtask

	function automatic logic [4:0] pin_exp();
		for (int i = 0; i < NUM_TIMERS; i++)
			pin_exp[i] = mode_s[i][MODE_PULSE_BIT] ? (run_s[i] ? tog[i] ^ pol_s[i] : pol_s[i]) : gpio_s[i];
	endfunction

	task automatic check_all();
		logic [31:0] v;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			rd(8'(OFS_TIMER_BASE + OFS_STRIDE * i), v);
			chk("count", 32'(cnt[i]), v);
		end
		rd(OFS_IRQ_STAT, v);
		chk("irq_stat", 32'(stat), v);
		chk("irq", 32'(|(stat & mask)), 32'(irq));
		chk("out_pins", 32'(pin_exp()), 32'(timer_pulse_output_pin));
	endtask

	task automatic tb2_pulses(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			tb2_req <= 1'b1;
			@(posedge sys_clk);
			tb2_req <= 1'b0;
			repeat (6) @(posedge sys_clk);
			for (int i = 0; i < NUM_TIMERS; i++) if (src_s[2*i+:2] == SRC_TB2) tk(i);
		end
	endtask

	// kind 0 ignored, 1 counted at rising edge, 2 counted at falling edge
	task automatic pin_pulse(input int i, input int kind);
		logic [31:0] v;
		@(posedge sys_clk);
		pin_req[i] <= 1'b1;
		@(posedge sys_clk);
		pin_req[i] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		if (kind == 1) tk(i);
		rd(8'(OFS_TIMER_BASE + OFS_STRIDE * i), v);
		chk("mid_pulse", 32'(cnt[i]), v);
		repeat (14) @(posedge sys_clk);
		if (kind == 2) tk(i);
	endtask

	task automatic summarize();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		summarize();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v;
		int          n, up;
		seed = 32'hdfef;
		{rstn, addr, wdata, wr_stb, rd_stb, pin_req, tb2_req} = '0;
		{run_s, dir_s, pol_s, fn_s, gpio_s, src_s, stat, mask} = '0;
		for (int i = 0; i < 5; i++) {cnt[i], rld[i], mode_s[i], tog[i]} = '0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		check_all();
		rd(8'h3c, v);
		chk("unmapped", 32'h0, v);
		wr(OFS_SRC, 32'h349);
		wr(OFS_DIR, 32'h19);
		wr(OFS_TIMER_BASE, 32'hfffd);
		wr(OFS_TIMER_BASE + 8'h04, 32'h1);
		wr(OFS_TIMER_BASE + 8'h0c, 32'h10);
		wr(OFS_TIMER_BASE + 8'h10, 32'hffff);
		wr(OFS_MODE_BASE + 8'h10, 32'h1);
		wr(OFS_MODE_BASE + 8'h08, 32'ha);
		wr(OFS_POL, 32'h02);
		wr(OFS_GPIO_OUT, 32'h04);
		wr(OFS_IRQ_MASK, 32'h1f);
		check_all();
		wr(OFS_START, 32'h1b);
		tb2_pulses(3);
		check_all();
		wr(OFS_TIMER_BASE, 32'hfffe);
		check_all();
		tb2_pulses(3);
		check_all();
		wr(OFS_IRQ_STAT, 32'h1f);
		wr(OFS_IRQ_MASK, 32'h02);
		tb2_pulses(2);
		check_all();
		wr(OFS_IRQ_MASK, 32'h11);
		check_all();
		wr(OFS_START, 32'h0a);
		tb2_pulses(1);
		check_all();
		wr(OFS_POL, 32'h12);
		check_all();
		wr(OFS_START, 32'h0e);
		pin_pulse(2, 0);
		wr(OFS_PINFN, 32'h04);
		pin_pulse(2, 1);
		wr(OFS_MODE_BASE + 8'h08, 32'h2);
		pin_pulse(2, 2);
		check_all();
		for (int k = 0; k < 4; k++) begin
			up = $random(seed) & 1;
			n = $random(seed) & 3;
			if (up) n = n ^ 'hffff;
			wr(OFS_START, 32'h06);
			wr(OFS_DIR, 32'h11 | (up << 3));
			wr(OFS_TIMER_BASE + 8'h0c, n);
			wr(OFS_START, 32'h0e);
			tb2_pulses(($random(seed) & 7) + 1);
			check_all();
		end
		wr(OFS_PRESC, 32'h1);
		rd(OFS_PRESC, v);
		chk("presc_small", 32'h1, 32'(v < 8));
		summarize();
	end
endmodule
